// File: rtl/charge_state_sequencer.sv
// charge state machine with safety timers, status outputs and gate control
// Notes on behaviour
// - full charge asserts cv flag low and charges at constant voltage.
// - full charge goes to top-off on current below 10% or timer expiry.
// - top-off keeps constant voltage until its timer expires, then done.
// - done idles with no charge until recharge threshold, then reset.
// - temperature fault in full or top-off pauses charge and freezes timer.
// - temperature fault in fast charge pauses charge and suspends timers.
// - temperature pause forces zero current and leaves indicators unchanged.
// - reset on power-up, recharge from done, input dropout or overvoltage.
// - reset clears timers, zero current, all indicators released high.
// - reset leaves for prequalification once supply, reference, bias are good.
// - prequalification advances to fast charge above undervoltage threshold.
// - fast charge commands full current, 90 min fast timer, cc flag only.
// - fast to full at regulation voltage; 90 min slow timer, cv flag only.
// - done commands zero current with all indicators inactive.
// - prequal or fast timeout enters fault: zero current, fault flag only.
// - gates get about 50 ns dead time so both are never on.
// - zero inductor current switches the rectifier off for that cycle.
// - power-down low stops charging, gates low, flags float; release resets.
// - fault persists until power is cycled or power-down is driven low.
// - each temperature measurement holds both gates low for 800 us.
// - safety timers always run in their states and cannot be disabled.
`timescale 1ns/1ps
module charge_state_sequencer #(
  parameter longint unsigned TICK_SLOW_CYC =
    64'(chg_pkg::SLOW_TICK_MS) * chg_pkg::CLK_MHZ * 1000,
  parameter longint unsigned TICK_FAST_CYC =
    64'(chg_pkg::FAST_TICK_MS) * chg_pkg::CLK_MHZ * 1000,
  parameter int unsigned THM_CYC = chg_pkg::THM_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic power_down_n,
  input wire logic supply_ok,
  input wire logic ref_ok,
  input wire logic bias_ok,
  input wire logic dropout,
  input wire logic overvoltage,
  input wire logic above_undervoltage,
  input wire logic at_regulation,
  input wire logic below_tenth_current,
  input wire logic below_recharge,
  input wire logic temp_ok,
  input wire logic temp_measure,
  input wire logic pwm_high,
  input wire logic zero_current,
  output logic [1:0] current_cmd,
  output logic cc_phase_flag_n,
  output logic cc_phase_flag_oe,
  output logic cv_phase_flag_n,
  output logic cv_phase_flag_oe,
  output logic fault_flag_n,
  output logic fault_flag_oe,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic [2:0] state_out
);
  chg_pkg::chg_state_t state_q, state_d, resume_q;
  logic pd_prev_q;
  logic [31:0] thm_q;
  logic slow_clear, fast_clear, slow_run, fast_run, slow_exp, fast_exp;
  logic [7:0] slow_limit;
  logic gate_en;

  // leaving power-down restarts the cycle from reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pd_prev_q <= 1'b1; // idle level, so no false release edge
    end else if (ce) begin
      pd_prev_q <= power_down_n;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      chg_pkg::ST_RESET: if (supply_ok && ref_ok && bias_ok) state_d = chg_pkg::ST_PREQ;
      chg_pkg::ST_PREQ: begin
        if (slow_exp) state_d = chg_pkg::ST_FAULT;
        else if (above_undervoltage && temp_ok) state_d = chg_pkg::ST_FAST;
      end
      chg_pkg::ST_FAST: begin
        if (!temp_ok) state_d = chg_pkg::ST_TEMP;
        else if (fast_exp) state_d = chg_pkg::ST_FAULT;
        else if (at_regulation) state_d = chg_pkg::ST_FULL;
      end
      chg_pkg::ST_FULL: begin
        if (!temp_ok) state_d = chg_pkg::ST_TEMP;
        else if (below_tenth_current || slow_exp) state_d = chg_pkg::ST_TOP;
      end
      chg_pkg::ST_TOP: begin
        if (!temp_ok) state_d = chg_pkg::ST_TEMP;
        else if (slow_exp) state_d = chg_pkg::ST_DONE;
      end
      chg_pkg::ST_DONE: if (below_recharge) state_d = chg_pkg::ST_RESET;
      chg_pkg::ST_TEMP: if (temp_ok) state_d = resume_q;
      chg_pkg::ST_FAULT: state_d = chg_pkg::ST_FAULT;
      default: state_d = chg_pkg::ST_RESET;
    endcase
    // dropout and overvoltage force reset, except a latched fault
    if ((dropout || overvoltage) && state_q != chg_pkg::ST_FAULT) begin
      state_d = chg_pkg::ST_RESET;
    end
    if (power_down_n && !pd_prev_q) begin
      state_d = chg_pkg::ST_RESET;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= chg_pkg::ST_RESET;
      resume_q <= chg_pkg::ST_FAST;
    end else if (ce) begin
      if (!power_down_n) begin
        state_q <= chg_pkg::ST_RESET;
      end else begin
        state_q <= state_d;
        if (state_d == chg_pkg::ST_TEMP && state_q != chg_pkg::ST_TEMP) begin
          resume_q <= state_q;
        end
      end
    end
  end

  // slow timer clears in reset and on prequal to fast, fast to full and full to top-off, not on resume; fast timer only in reset; both freeze in the pause
  assign slow_clear = (state_q == chg_pkg::ST_RESET) || !power_down_n
    || (state_q == chg_pkg::ST_PREQ && state_d == chg_pkg::ST_FAST)
    || (state_q == chg_pkg::ST_FAST && state_d == chg_pkg::ST_FULL)
    || (state_q == chg_pkg::ST_FULL && state_d == chg_pkg::ST_TOP);
  assign fast_clear = (state_q == chg_pkg::ST_RESET) || !power_down_n;
  assign slow_run = state_q == chg_pkg::ST_PREQ || state_q == chg_pkg::ST_FULL
    || state_q == chg_pkg::ST_TOP;
  assign fast_run = state_q == chg_pkg::ST_FAST;

  always_comb begin
    case (state_q)
      chg_pkg::ST_FULL: slow_limit = chg_pkg::FULL_TICKS;
      chg_pkg::ST_TOP: slow_limit = chg_pkg::TOP_TICKS;
      default: slow_limit = chg_pkg::PREQ_TICKS;
    endcase
  end

  tick_timer #(.PRESCALE(TICK_SLOW_CYC)) u_slow (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clear(slow_clear),
    .run(slow_run),
    .limit(slow_limit),
    .expired(slow_exp)
  );

  tick_timer #(.PRESCALE(TICK_FAST_CYC)) u_fast (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clear(fast_clear),
    .run(fast_run),
    .limit(chg_pkg::FAST_TICKS),
    .expired(fast_exp)
  );

  // current command and registered status flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      current_cmd <= chg_pkg::CUR_ZERO;
      state_out <= 3'h0;
    end else if (ce) begin
      state_out <= state_d;
      case (state_d)
        chg_pkg::ST_PREQ: current_cmd <= chg_pkg::CUR_C20;
        chg_pkg::ST_FAST: current_cmd <= chg_pkg::CUR_FULL;
        chg_pkg::ST_FULL, chg_pkg::ST_TOP: current_cmd <= chg_pkg::CUR_CV;
        chg_pkg::ST_DONE: current_cmd <= chg_pkg::CUR_ZERO;
        default: current_cmd <= chg_pkg::CUR_ZERO;
      endcase
      if (!power_down_n) begin
        current_cmd <= chg_pkg::CUR_ZERO;
        state_out <= chg_pkg::ST_RESET;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cc_phase_flag_n <= 1'b1;
      cv_phase_flag_n <= 1'b1;
      fault_flag_n <= 1'b1;
      cc_phase_flag_oe <= 1'b0;
      cv_phase_flag_oe <= 1'b0;
      fault_flag_oe <= 1'b0;
    end else if (ce) begin
      if (state_d != chg_pkg::ST_TEMP) begin
        cc_phase_flag_n <= !(state_d == chg_pkg::ST_FAST || state_d == chg_pkg::ST_PREQ);
        cv_phase_flag_n <= !(state_d == chg_pkg::ST_FULL);
        fault_flag_n <= !(state_d == chg_pkg::ST_FAULT);
        cc_phase_flag_oe <= power_down_n && (state_d == chg_pkg::ST_FAST
          || state_d == chg_pkg::ST_PREQ);
        cv_phase_flag_oe <= power_down_n && state_d == chg_pkg::ST_FULL;
        fault_flag_oe <= power_down_n && state_d == chg_pkg::ST_FAULT;
      end
      if (!power_down_n) begin
        cc_phase_flag_n <= 1'b1;
        cv_phase_flag_n <= 1'b1;
        fault_flag_n <= 1'b1;
        cc_phase_flag_oe <= 1'b0;
        cv_phase_flag_oe <= 1'b0;
        fault_flag_oe <= 1'b0;
      end
    end
  end

  // temperature measurement blanking window
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      thm_q <= 32'h0000_0000;
    end else if (ce) begin
      if (temp_measure && thm_q == 32'h0000_0000) begin
        thm_q <= 32'(THM_CYC);
      end else if (thm_q != 32'h0000_0000) begin
        thm_q <= thm_q - 32'h0000_0001;
      end
    end
  end

  assign gate_en = power_down_n && thm_q == 32'h0000_0000 && !temp_measure
    && current_cmd != chg_pkg::CUR_ZERO;

  gate_driver u_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .enable(gate_en),
    .pwm_high(pwm_high),
    .zero_current(zero_current),
    .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate)
  );

  a_fault_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_FAULT && power_down_n && ce |=> state_q == chg_pkg::ST_FAULT)
    else $error("fault left");
  a_temp_zero: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_TEMP |-> current_cmd == chg_pkg::CUR_ZERO)
    else $error("current in pause");
  a_temp_flags: assert property (@(posedge ref_clk) disable iff (rst)
    ce && power_down_n && state_q == chg_pkg::ST_TEMP && state_d == chg_pkg::ST_TEMP
    |=> $stable(cc_phase_flag_n) && $stable(cv_phase_flag_n) && $stable(fault_flag_n))
    else $error("flags moved in pause");
  a_reset_flags: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_RESET |-> cc_phase_flag_n && cv_phase_flag_n && fault_flag_n)
    else $error("flag low in reset");
  a_full_cv: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_FULL |-> !cv_phase_flag_n && cc_phase_flag_n
    && current_cmd == chg_pkg::CUR_CV) else $error("full charge outputs");
  a_done_idle: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_DONE |-> current_cmd == chg_pkg::CUR_ZERO
    && cc_phase_flag_n && cv_phase_flag_n && fault_flag_n) else $error("charging in done");
  a_pd_gates: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !power_down_n |=> ##1 !high_side_gate && !low_side_gate)
    else $error("gates on in power-down");
  a_fast_fault: assert property (@(posedge ref_clk) disable iff (rst)
    ce && power_down_n && state_q == chg_pkg::ST_FAST && temp_ok && fast_exp
    && !dropout && !overvoltage |=> state_q == chg_pkg::ST_FAULT)
    else $error("fast timeout missed");
  a_thm_blank: assert property (@(posedge ref_clk) disable iff (rst)
    thm_q != 32'h0000_0000 |=> !high_side_gate && !low_side_gate)
    else $error("gates during measurement");

  c_reach_full: cover property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_FULL);
  c_reach_done: cover property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_DONE);
  c_temp_pause: cover property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_TEMP);
  c_fault: cover property (@(posedge ref_clk) disable iff (rst)
    state_q == chg_pkg::ST_FAULT);
endmodule // charge_state_sequencer

// File: inc/chg_pkg.sv
// shared constants and types for the charge state sequencer
package chg_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // dead time between gate hand-overs, in ns, and its cycle count (rounded up)
  localparam int unsigned DEAD_NS = 50;
  localparam logic [7:0] DEAD_CYC = 8'((DEAD_NS * CLK_MHZ + 999) / 1000);
  // gate blanking per temperature measurement, in us
  localparam int unsigned THM_US = 800;
  localparam int unsigned THM_CYC_DEF = THM_US * CLK_MHZ;
  // timer tick period in us (prescaler), and tick counts per limit
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC_DEF = TICK_US * CLK_MHZ;
  localparam int unsigned PREQ_MIN10 = 75;
  localparam int unsigned FAST_MIN = 90;
  localparam int unsigned FULL_MIN = 90;
  localparam int unsigned TOP_MIN = 45;
  // slow base: 1:12:6 counts of 7.5 min ticks; fast base: 1 min ticks
  localparam logic [7:0] PREQ_TICKS = 8'h01;
  localparam logic [7:0] FULL_TICKS = 8'h0C;
  localparam logic [7:0] TOP_TICKS = 8'h06;
  localparam logic [7:0] FAST_TICKS = 8'(FAST_MIN);
  localparam int unsigned SLOW_TICK_MS = PREQ_MIN10 * 6000;
  localparam int unsigned FAST_TICK_MS = 60000;
  // charge current command codes
  localparam logic [1:0] CUR_ZERO = 2'h0;
  localparam logic [1:0] CUR_C20 = 2'h1;
  localparam logic [1:0] CUR_FULL = 2'h2;
  localparam logic [1:0] CUR_CV = 2'h3;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_PREQ = 3'b001,
    ST_FAST = 3'b010,
    ST_FULL = 3'b011,
    ST_TOP = 3'b100,
    ST_DONE = 3'b101,
    ST_TEMP = 3'b110,
    ST_FAULT = 3'b111
  } chg_state_t;
endpackage

// File: rtl/tick_timer.sv
// prescaled tick timer that counts while enabled and flags its limit
`timescale 1ns/1ps
module tick_timer #(
  parameter longint unsigned PRESCALE = 1000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic run,
  input wire logic [7:0] limit,
  output logic expired
);
  // wide enough for a minutes-long tick at the full clock rate
  logic [39:0] pre_q;
  logic [7:0] ticks_q;

  // prescaler and tick count; hold while not running
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_q <= 40'h00_0000_0000;
      ticks_q <= 8'h00;
    end else if (ce) begin
      if (clear) begin
        pre_q <= 40'h00_0000_0000;
        ticks_q <= 8'h00;
      end else if (run && !expired) begin
        if (pre_q >= 40'(PRESCALE - 1)) begin
          pre_q <= 40'h00_0000_0000;
          ticks_q <= ticks_q + 8'h01;
        end else begin
          pre_q <= pre_q + 40'h00_0000_0001;
        end
      end
    end
  end

  assign expired = (ticks_q >= limit);
endmodule // tick_timer

// File: rtl/gate_driver.sv
// dead-time gate sequencing with zero-current cutoff and blanking
`timescale 1ns/1ps
module gate_driver (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic pwm_high,
  input wire logic zero_current,
  output logic high_side_gate,
  output logic low_side_gate
);
  logic [7:0] dead_q;
  logic zc_lock_q;
  logic pwm_prev_q;

  // zero-current latch clears at the next high-side request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      zc_lock_q <= 1'b0;
      pwm_prev_q <= 1'b0;
    end else if (ce) begin
      pwm_prev_q <= pwm_high;
      if (pwm_high && !pwm_prev_q) begin
        zc_lock_q <= 1'b0;
      end else if (zero_current && !pwm_high) begin
        zc_lock_q <= 1'b1;
      end
    end
  end

  // gates hand over only after the dead time with both off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      high_side_gate <= 1'b0;
      low_side_gate <= 1'b0;
      dead_q <= 8'h00;
    end else if (ce) begin
      if (!enable) begin
        high_side_gate <= 1'b0;
        low_side_gate <= 1'b0;
        dead_q <= 8'h00;
      end else if (pwm_high) begin
        low_side_gate <= 1'b0;
        if (low_side_gate) begin
          dead_q <= 8'h00;
        end else if (dead_q < chg_pkg::DEAD_CYC) begin
          dead_q <= dead_q + 8'h01;
        end else begin
          high_side_gate <= 1'b1;
        end
      end else begin
        high_side_gate <= 1'b0;
        if (high_side_gate) begin
          dead_q <= 8'h00;
        end else if (dead_q < chg_pkg::DEAD_CYC) begin
          dead_q <= dead_q + 8'h01;
        end else if (zc_lock_q || zero_current) begin
          low_side_gate <= 1'b0;
          // a zero-current cutoff also restarts the dead time before the high side
          if (low_side_gate) begin
            dead_q <= 8'h00;
          end
        end else begin
          low_side_gate <= 1'b1;
        end
      end
    end
  end

  a_no_overlap: assert property (@(posedge ref_clk) disable iff (rst)
    !(high_side_gate && low_side_gate)) else $error("both gates on");
  a_dead_gap: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(low_side_gate) |-> !high_side_gate [*8]) else $error("dead time short");
  a_dead_gap_high: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(high_side_gate) |-> !low_side_gate [*8]) else $error("dead time short");
  a_zc_off: assert property (@(posedge ref_clk) disable iff (rst)
    ce && zero_current && !pwm_high |=> !low_side_gate) else $error("sync on at zero");
  a_off_disable: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !enable |=> !high_side_gate && !low_side_gate) else $error("gate on disabled");
endmodule // gate_driver

// File: test/sense_model.sv
// behavioural battery sense comparators and external switch pair
`timescale 1ns/1ps
module sense_model #(
  parameter int UV_MV = 3000,
  parameter int REG_MV = 4200,
  parameter int RECH_MV = 4000,
  parameter int ZC_CYC = 6
) (
  input wire logic ref_clk,
  input wire logic [15:0] battery_sense_mv,
  input wire logic light_load,
  input wire logic taper,
  input wire logic [1:0] current_cmd,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  output logic above_undervoltage,
  output logic at_regulation,
  output logic below_recharge,
  output logic below_tenth_current,
  output logic zero_current,
  output logic shoot_thru
);
  int lo_cnt = 0;
  assign above_undervoltage = int'(battery_sense_mv) > UV_MV;
  assign at_regulation = int'(battery_sense_mv) >= REG_MV;
  assign below_recharge = int'(battery_sense_mv) < RECH_MV;
  // current only tapers while the charger holds constant voltage
  assign below_tenth_current = taper && current_cmd == chg_pkg::CUR_CV;
  initial begin
    zero_current = 1'b0;
    shoot_thru = 1'b0;
  end
  always @(posedge ref_clk) begin
    lo_cnt <= low_side_gate ? lo_cnt + 1 : 0;
    // light load drains the inductor while the rectifier conducts
    zero_current <= light_load && lo_cnt >= ZC_CYC;
    if (high_side_gate && low_side_gate) begin
      shoot_thru <= 1'b1;
    end
  end
endmodule // sense_model

// File: test/charge_state_sequencer_tb.sv
// self-checking bench for the charge state sequencer
`timescale 1ns/1ps
module charge_state_sequencer_tb;
  logic ref_clk = 1'b0, rst = 1'b1, power_down_n = 1'b1, dropout = 1'b0, overvoltage = 1'b0;
  logic supply_ok = 1'b0, ref_ok = 1'b0, bias_ok = 1'b0, temp_ok = 1'b1, temp_measure = 1'b0;
  logic pwm_high = 1'b0, pwm_en = 1'b0, light_load = 1'b0, taper = 1'b0;
  logic [15:0] battery_sense_mv = 16'h07D0;
  logic above_undervoltage, at_regulation, below_tenth_current, below_recharge, zero_current;
  logic shoot_thru, cc_phase_flag_n, cc_phase_flag_oe, cv_phase_flag_n, cv_phase_flag_oe;
  logic fault_flag_n, fault_flag_oe, high_side_gate, low_side_gate;
  logic [1:0] current_cmd;
  logic [2:0] state_out;
  int fail_count = 0, checks = 0, n;
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always begin
    repeat (40) @(posedge ref_clk);
    #1 pwm_high = pwm_en & ~pwm_high;
  end
  charge_state_sequencer #(.TICK_SLOW_CYC(20), .TICK_FAST_CYC(20), .THM_CYC(10))
    charge_state_sequencer_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .power_down_n(power_down_n), .supply_ok(supply_ok), .ref_ok(ref_ok), .bias_ok(bias_ok),
    .dropout(dropout), .overvoltage(overvoltage), .above_undervoltage(above_undervoltage),
    .at_regulation(at_regulation), .below_tenth_current(below_tenth_current),
    .below_recharge(below_recharge), .temp_ok(temp_ok), .temp_measure(temp_measure),
    .pwm_high(pwm_high), .zero_current(zero_current), .current_cmd(current_cmd),
    .cc_phase_flag_n(cc_phase_flag_n), .cc_phase_flag_oe(cc_phase_flag_oe),
    .cv_phase_flag_n(cv_phase_flag_n), .cv_phase_flag_oe(cv_phase_flag_oe),
    .fault_flag_n(fault_flag_n), .fault_flag_oe(fault_flag_oe),
    .high_side_gate(high_side_gate), .low_side_gate(low_side_gate), .state_out(state_out));
  sense_model sense_model_inst (.ref_clk(ref_clk), .battery_sense_mv(battery_sense_mv), .light_load(light_load),
    .taper(taper), .current_cmd(current_cmd), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .above_undervoltage(above_undervoltage),
    .at_regulation(at_regulation), .below_recharge(below_recharge),
    .below_tenth_current(below_tenth_current), .zero_current(zero_current),
    .shoot_thru(shoot_thru));
  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // a: active flags as {cc, cv, fault}
  task automatic exp_st(input logic [2:0] s, input logic [1:0] c, input logic [2:0] a);
    chk({5'h0, state_out}, {5'h0, s});
    chk({6'h0, current_cmd}, {6'h0, c});
    chk({2'h0, cc_phase_flag_n, cc_phase_flag_oe, cv_phase_flag_n, cv_phase_flag_oe,
      fault_flag_n, fault_flag_oe}, {2'h0, ~a[2], a[2], ~a[1], a[1], ~a[0], a[0]});
  endtask
  task automatic wait_st(input logic [2:0] s, input int bound);
    n = 0;
    while (state_out !== s && n < bound) begin
      step(1);
      n++;
    end
    if (state_out !== s) begin
      chk({5'h0, state_out}, {5'h0, s});
      tally_and_finish();
    end
  endtask
  task automatic gates(input logic [1:0] want);
    chk({6'h0, high_side_gate, low_side_gate}, {6'h0, want});
  endtask
  task automatic pwm_rise();
    for (int i = 0; i < 90 && !(pwm_high === 1'b0); i++) step(1);
    for (int i = 0; i < 90 && !(pwm_high === 1'b1); i++) step(1);
  endtask
  task automatic t_reset_hold();
    exp_st(chg_pkg::ST_RESET, chg_pkg::CUR_ZERO, 3'h0);
    for (int i = 0; i < 3; i++) begin
      {supply_ok, ref_ok, bias_ok} = 3'h7 ^ (3'h1 << i);
      step(4);
      exp_st(chg_pkg::ST_RESET, chg_pkg::CUR_ZERO, 3'h0);
    end
    bias_ok = 1'b1;
    supply_ok = 1'b1;
    ref_ok = 1'b1;
    wait_st(chg_pkg::ST_PREQ, 3);
    exp_st(chg_pkg::ST_PREQ, chg_pkg::CUR_C20, 3'h4);
    wait_st(chg_pkg::ST_FAULT, 45);
    exp_st(chg_pkg::ST_FAULT, chg_pkg::CUR_ZERO, 3'h1);
  endtask
  task automatic t_fault_hold();
    pwm_en = 1'b1;
    dropout = 1'b1;
    step(3);
    dropout = 1'b0;
    overvoltage = 1'b1;
    step(3);
    overvoltage = 1'b0;
    battery_sense_mv = 16'h0DAC;
    step(90);
    exp_st(chg_pkg::ST_FAULT, chg_pkg::CUR_ZERO, 3'h1);
    gates(2'h0);
    power_down_n = 1'b0;
    step(3);
    gates(2'h0);
    chk({5'h0, cc_phase_flag_oe, cv_phase_flag_oe, fault_flag_oe}, 8'h0);
    chk({5'h0, state_out}, {5'h0, chg_pkg::ST_RESET});
    power_down_n = 1'b1;
    wait_st(chg_pkg::ST_FAST, 6);
  endtask
  task automatic t_charge_cycle();
    exp_st(chg_pkg::ST_FAST, chg_pkg::CUR_FULL, 3'h4);
    temp_ok = 1'b0;
    step(3);
    exp_st(chg_pkg::ST_TEMP, chg_pkg::CUR_ZERO, 3'h4);
    temp_ok = 1'b1;
    wait_st(chg_pkg::ST_FAST, 4);
    battery_sense_mv = 16'h1068;
    wait_st(chg_pkg::ST_FULL, 4);
    exp_st(chg_pkg::ST_FULL, chg_pkg::CUR_CV, 3'h2);
    taper = 1'b1;
    wait_st(chg_pkg::ST_TOP, 4);
    exp_st(chg_pkg::ST_TOP, chg_pkg::CUR_CV, 3'h0);
    wait_st(chg_pkg::ST_DONE, 160);
    chk({7'h0, n >= 95}, 8'h1);
    exp_st(chg_pkg::ST_DONE, chg_pkg::CUR_ZERO, 3'h0);
    step(100);
    gates(2'h0);
    chk({5'h0, state_out}, {5'h0, chg_pkg::ST_DONE});
    taper = 1'b0;
    battery_sense_mv = 16'h0F3C;
    wait_st(chg_pkg::ST_RESET, 4);
    exp_st(chg_pkg::ST_RESET, chg_pkg::CUR_ZERO, 3'h0);
  endtask
  task automatic t_full_timer();
    battery_sense_mv = 16'h1068;
    wait_st(chg_pkg::ST_FULL, 10);
    n = 0;
    for (int i = 0; i < 700 && state_out !== chg_pkg::ST_TOP; i++) begin
      temp_ok = !(i >= 50 && i < 350);
      if (state_out === chg_pkg::ST_FULL) n++;
      if (i == 100) exp_st(chg_pkg::ST_TEMP, chg_pkg::CUR_ZERO, 3'h2);
      step(1);
    end
    chk({7'h0, n >= 215 && n <= 265}, 8'h1);
    exp_st(chg_pkg::ST_TOP, chg_pkg::CUR_CV, 3'h0);
  endtask
  task automatic t_resets();
    for (int k = 0; k < 2; k++) begin
      battery_sense_mv = 16'h0DAC;
      wait_st(chg_pkg::ST_FAST, 200);
      {dropout, overvoltage} = k ? 2'h1 : 2'h2;
      wait_st(chg_pkg::ST_RESET, 4);
      exp_st(chg_pkg::ST_RESET, chg_pkg::CUR_ZERO, 3'h0);
      {dropout, overvoltage} = 2'h0;
    end
    wait_st(chg_pkg::ST_FAST, 10);
  endtask
  task automatic t_gates();
    pwm_rise();
    step(30);
    gates(2'h2);
    step(40);
    gates(2'h1);
    light_load = 1'b1;
    pwm_rise();
    step(70);
    gates(2'h0);
    step(8);
    gates(2'h0);
    light_load = 1'b0;
    pwm_rise();
    temp_measure = 1'b1;
    step(1);
    temp_measure = 1'b0;
    step(5);
    gates(2'h0);
    step(4);
    gates(2'h0);
    step(28);
    gates(2'h2);
  endtask
  initial begin
    step(8);
    rst = 1'b0;
    t_reset_hold();
    t_fault_hold();
    t_charge_cycle();
    t_full_timer();
    t_resets();
    t_gates();
    wait_st(chg_pkg::ST_FAULT, 2000);
    exp_st(chg_pkg::ST_FAULT, chg_pkg::CUR_ZERO, 3'h1);
    chk({7'h0, shoot_thru}, 8'h0);
    tally_and_finish();
  end
endmodule // charge_state_sequencer_tb
